// ===== src/sadc_seq.sv
/*
 * Sequencer of an 8-bit successive-approximation converter with mode, start and result registers.
 * Assumes a synchronous CPU register port and an analog comparator that answers within a cycle.
 */
`timescale 1ns/1ns
`include "sadc_consts.svh"
module sadc_seq
    import sadc_pkg::*;
#(
    parameter int SLOW_CLKS = `SADC_CLK_SLOW,
    parameter int FAST_CLKS = `SADC_CLK_FAST
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire sadc_pkg::sadc_bus_s bus,
    output logic [7:0] rdata,
    input wire logic ext_trigger_pin,
    input wire logic trigger_pin_function_bit,
    input wire logic trigger_edge_select,
    input wire logic comp_out,
    output logic [7:0] dac_code,
    output logic [11:0] chan_onehot,
    output logic sample_hold,
    output logic start_busy_flag,
    output logic conv_end_request_flag
);
    import sadc_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [11:0] decode_chan(input logic [3:0] ch);
        logic [11:0] oh;
        oh = 12'h000;
        if (ch[3]) begin
            oh[4 + ch[2:0]] = 1'b1;
        end else if (ch[2]) begin
            oh[ch[1:0]] = 1'b1;
        end
        return oh;
    endfunction

    localparam logic [5:0] SLOW_STEP = 6'(SLOW_CLKS / `SADC_STEPS);
    localparam logic [5:0] FAST_STEP = 6'(FAST_CLKS / `SADC_STEPS);
    localparam logic [5:0] SLOW_SAMP = 6'(SLOW_CLKS - `SADC_STEPS * (SLOW_CLKS / `SADC_STEPS));
    localparam logic [5:0] FAST_SAMP = 6'(FAST_CLKS - `SADC_STEPS * (FAST_CLKS / `SADC_STEPS));

    sadc_mode_s conv_mode_reg;
    logic [7:0] conv_result_reg;
    logic [7:0] sar_reg;
    logic [7:0] bit_reg;
    logic [5:0] cnt_reg;
    logic fast_reg;
    sadc_state_e state_reg;
    logic trig_prev_reg;
    logic trig_edge;
    logic wr_start;
    logic wr_stop;
    logic start_req;
    logic done;
    logic step_end;
    logic [5:0] step_len;
    logic [5:0] samp_len;

    // ------------------------------------------------------------------------
    // Start sources
    // ------------------------------------------------------------------------
    assign wr_start = bus.wr && bus.addr == `SADC_OFS_START && bus.wdata[`SADC_BIT_BUSY];
    assign wr_stop = bus.wr && bus.addr == `SADC_OFS_START && !bus.wdata[`SADC_BIT_BUSY];
    // The pin is sampled once per enabled cycle so the edge is seen against its previous level.
    assign trig_edge = trigger_edge_select ? (ext_trigger_pin && !trig_prev_reg)
                                           : (!ext_trigger_pin && trig_prev_reg);
    assign start_req = wr_start || (trig_edge && conv_mode_reg.trig_en
                                    && trigger_pin_function_bit);
    assign step_len = fast_reg ? FAST_STEP : SLOW_STEP;
    assign samp_len = fast_reg ? FAST_SAMP : SLOW_SAMP;
    assign step_end = cnt_reg == 6'h01;
    assign done = state_reg == SADC_DECIDE && step_end && bit_reg[0] && !wr_stop;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_prev_reg <= 1'b0;
        end else if (clk_en) begin
            trig_prev_reg <= ext_trigger_pin;
        end
    end

    // ------------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_mode_reg <= '0;
        end else if (clk_en && bus.wr && bus.addr == `SADC_OFS_MODE) begin
            conv_mode_reg.speed_fast <= bus.wdata[`SADC_BIT_SPEED];
            conv_mode_reg.trig_en <= bus.wdata[`SADC_BIT_TRIG];
            conv_mode_reg.channel <= bus.wdata[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SADC_IDLE;
            cnt_reg <= 6'h00;
            bit_reg <= 8'h00;
            sar_reg <= 8'h00;
            fast_reg <= 1'b0;
            chan_onehot <= 12'h000;
            start_busy_flag <= 1'b0;
            sample_hold <= 1'b0;
        end else if (clk_en) begin
            case (state_reg)
                SADC_IDLE: begin
                    if (start_req) begin
                        state_reg <= SADC_SAMPLE;
                        fast_reg <= conv_mode_reg.speed_fast;
                        cnt_reg <= (conv_mode_reg.speed_fast ? FAST_SAMP : SLOW_SAMP)
                                   + (conv_mode_reg.speed_fast ? FAST_STEP : SLOW_STEP);
                        chan_onehot <= decode_chan(conv_mode_reg.channel);
                        start_busy_flag <= 1'b1;
                        sample_hold <= 1'b1;
                        sar_reg <= 8'h80;
                        bit_reg <= 8'h80;
                    end
                end
                SADC_SAMPLE: begin
                    if (wr_stop) begin
                        state_reg <= SADC_IDLE;
                        start_busy_flag <= 1'b0;
                        sample_hold <= 1'b0;
                        chan_onehot <= 12'h000;
                    end else if (cnt_reg == step_len + 6'h01) begin
                        state_reg <= SADC_DECIDE;
                        sample_hold <= 1'b0;
                        cnt_reg <= cnt_reg - 6'h01;
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                SADC_DECIDE: begin
                    if (wr_stop) begin
                        state_reg <= SADC_IDLE;
                        start_busy_flag <= 1'b0;
                        chan_onehot <= 12'h000;
                    end else if (step_end) begin
                        // MSB-first trial: keep the bit when the input is at or above the trial code.
                        if (!comp_out) begin
                            sar_reg <= (sar_reg & ~bit_reg) | (bit_reg >> 1);
                        end else begin
                            sar_reg <= sar_reg | (bit_reg >> 1);
                        end
                        bit_reg <= bit_reg >> 1;
                        cnt_reg <= step_len;
                        if (bit_reg[0]) begin
                            state_reg <= SADC_IDLE;
                            start_busy_flag <= 1'b0;
                            chan_onehot <= 12'h000;
                        end
                    end else begin
                        cnt_reg <= cnt_reg - 6'h01;
                    end
                end
                default: begin
                    state_reg <= SADC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_code <= 8'h00;
        end else if (clk_en) begin
            dac_code <= sar_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Result register and request flag
    // ------------------------------------------------------------------------
    // The result has no reset so a system reset leaves the last conversion readable.
    always_ff @(posedge clk) begin
        if (clk_en && done) begin
            conv_result_reg <= comp_out ? sar_reg : (sar_reg & ~bit_reg);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_end_request_flag <= 1'b0;
        end else if (clk_en) begin
            // Clearing lives in the interrupt controller; here the flag pulses once per end.
            conv_end_request_flag <= done;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (clk_en && bus.rd) begin
            case (bus.addr)
                `SADC_OFS_MODE: rdata <= {conv_mode_reg.speed_fast, conv_mode_reg.trig_en,
                                          2'b11, conv_mode_reg.channel};
                `SADC_OFS_RESULT: rdata <= conv_result_reg;
                `SADC_OFS_START: rdata <= {start_busy_flag, 7'h7F};
                default: rdata <= `SADC_UNMAPPED_READ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------------------
    // Counting enabled busy cycles keeps the length check free of long repetitions.
    // A conversion length above 128 clocks would wrap this counter.
    localparam logic [6:0] SLOW_LAST = 7'(SLOW_CLKS - 1);
    localparam logic [6:0] FAST_LAST = 7'(FAST_CLKS - 1);
    logic [6:0] busy_len_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_len_reg <= 7'h00;
        end else if (clk_en) begin
            if (state_reg == SADC_IDLE) begin
                busy_len_reg <= 7'h00;
            end else begin
                busy_len_reg <= busy_len_reg + 7'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    property p_end_clears_busy;
        @(posedge clk) disable iff (rst) (clk_en && done) |=> !start_busy_flag;
    endproperty
    a_end_clears_busy: assert property (p_end_clears_busy) else $error("busy not cleared");

    property p_end_flag;
        @(posedge clk) disable iff (rst)
            ($fell(start_busy_flag) && !$past(wr_stop)) |-> conv_end_request_flag;
    endproperty
    a_end_flag: assert property (p_end_flag) else $error("end flag missing");

    property p_stop;
        @(posedge clk) disable iff (rst)
            (clk_en && wr_stop && state_reg != SADC_IDLE) |=> (state_reg == SADC_IDLE);
    endproperty
    a_stop: assert property (p_stop) else $error("abort ignored");

    property p_start;
        @(posedge clk) disable iff (rst)
            (clk_en && start_req && state_reg == SADC_IDLE) |=> start_busy_flag;
    endproperty
    a_start: assert property (p_start) else $error("start ignored");

    property p_trig_gate;
        @(posedge clk) disable iff (rst)
            (clk_en && state_reg == SADC_IDLE && !wr_start && !conv_mode_reg.trig_en)
            |=> !start_busy_flag;
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger not gated");

    property p_result_hold;
        @(posedge clk) disable iff (rst)
            (state_reg == SADC_IDLE && $past(state_reg) == SADC_IDLE)
            |-> $stable(conv_result_reg);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed");

    property p_chan_stable;
        @(posedge clk) disable iff (rst)
            (state_reg == SADC_DECIDE && $past(state_reg) != SADC_IDLE) |-> $stable(chan_onehot);
    endproperty
    a_chan_stable: assert property (p_chan_stable) else $error("channel moved");

    property p_fast_len;
        @(posedge clk) disable iff (rst)
            ($rose(start_busy_flag) && fast_reg && clk_en) |-> start_busy_flag [*8];
    endproperty
    a_fast_len: assert property (p_fast_len) else $error("conversion too short");

    property p_reserved;
        @(posedge clk) disable iff (rst)
            ($past(bus.rd) && $past(bus.addr) == `SADC_OFS_START && $past(clk_en))
            |-> rdata[6:0] == 7'h7F;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not one");

    property p_len;
        @(posedge clk) disable iff (rst)
            (clk_en && done) |-> busy_len_reg == (fast_reg ? FAST_LAST : SLOW_LAST);
    endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");

    property p_busy_read;
        @(posedge clk) disable iff (rst)
            ($past(bus.rd) && $past(bus.addr) == `SADC_OFS_START && $past(clk_en))
            |-> rdata[7] == $past(start_busy_flag);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy read wrong");

    property p_mode_rsvd;
        @(posedge clk) disable iff (rst)
            ($past(bus.rd) && $past(bus.addr) == `SADC_OFS_MODE && $past(clk_en))
            |-> rdata[5:4] == 2'b11;
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode reserved bits not one");

    property p_pin_func;
        @(posedge clk) disable iff (rst)
            (clk_en && state_reg == SADC_IDLE && !wr_start && !trigger_pin_function_bit)
            |=> !start_busy_flag;
    endproperty
    a_pin_func: assert property (p_pin_func) else $error("pin function not gated");

    property p_chan_onehot;
        @(posedge clk) disable iff (rst) $onehot0(chan_onehot);
    endproperty
    a_chan_onehot: assert property (p_chan_onehot) else $error("two channels selected");

    property p_no_chan;
        @(posedge clk) disable iff (rst)
            (clk_en && state_reg == SADC_IDLE && start_req
             && conv_mode_reg.channel[3:2] == 2'b00) |=> chan_onehot == 12'h000;
    endproperty
    a_no_chan: assert property (p_no_chan) else $error("channel selected for none");

    property p_msb_first;
        @(posedge clk) disable iff (rst)
            (clk_en && state_reg == SADC_IDLE && start_req)
            |=> (sar_reg == 8'h80 && bit_reg == 8'h80);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first trial not msb");

    property p_step_onehot;
        @(posedge clk) disable iff (rst) (state_reg != SADC_IDLE) |-> $onehot(bit_reg);
    endproperty
    a_step_onehot: assert property (p_step_onehot) else $error("trial bit lost");

    c_done: cover property (@(posedge clk) disable iff (rst) clk_en && done);
    c_abort: cover property (@(posedge clk) disable iff (rst)
        clk_en && wr_stop && state_reg == SADC_DECIDE);
    c_trig: cover property (@(posedge clk) disable iff (rst)
        clk_en && trig_edge && conv_mode_reg.trig_en && trigger_pin_function_bit);
    c_fast_done: cover property (@(posedge clk) disable iff (rst) clk_en && done && fast_reg);
    c_freeze: cover property (@(posedge clk) disable iff (rst) !clk_en && start_busy_flag);
endmodule

// ===== pkg/sadc_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts for the converter sequencer.
 * Assumes it is included by its bare name from the package and from the design file.
 */
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SADC_OFS_MODE 16'hFFC4
`define SADC_OFS_RESULT 16'hFFC5
`define SADC_OFS_START 16'hFFC6

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define SADC_MODE_RESET 8'h30
`define SADC_MODE_RSVD 8'h30
`define SADC_START_RSVD 8'h7F
`define SADC_BIT_SPEED 7
`define SADC_BIT_TRIG 6
`define SADC_BIT_BUSY 7
`define SADC_UNMAPPED_READ 8'hFF

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SADC_CLK_SLOW 62
`define SADC_CLK_FAST 31
`define SADC_STEPS 8

`endif

// ===== pkg/sadc_pkg.sv
/*
 * Types shared by the converter sequencer.
 * Assumes the constants header sits beside it on the include path.
 */
package sadc_pkg;
    `include "sadc_consts.svh"

    typedef enum logic [1:0] {
        SADC_IDLE,
        SADC_SAMPLE,
        SADC_DECIDE
    } sadc_state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sadc_bus_s;

    typedef struct packed {
        logic speed_fast;
        logic trig_en;
        logic [3:0] channel;
    } sadc_mode_s;
endpackage

// ===== tb/sadc_analog_model.sv
/*
 * Analog side of the converter: twelve fixed input levels and the comparator.
 * Assumes the sequencer drives a one-hot channel select and a registered trial code.
 */
`timescale 1ns/1ns
module sadc_analog_model (
    input wire logic [11:0] chan_onehot,
    input wire logic [7:0] dac_code,
    input wire logic [95:0] levels,
    output logic comp_out
);
    // ------------------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------------------
    // With no channel selected the input floats, so the answer follows bit 0 of the trial code.
    always_comb begin
        comp_out = dac_code[0];
        for (int i = 0; i < 12; i++) begin
            if (chan_onehot[i]) begin
                comp_out = (levels[i*8 +: 8] >= dac_code);
            end
        end
    end
endmodule

// ===== tb/sadc_seq_tb_top.sv
/*
 * Self-checking bench for the converter sequencer: register access, conversions, triggers.
 * Assumes the package and its constants header are compiled first.
 */
`timescale 1ns/1ns
`include "sadc_consts.svh"
module sadc_seq_tb_top;
    import sadc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    sadc_pkg::sadc_bus_s bus = '0;
    logic ext_trigger_pin = 1'b0;
    logic trigger_pin_function_bit = 1'b0;
    logic trigger_edge_select = 1'b1;
    logic [95:0] levels;
    logic comp_out;
    logic [7:0] rdata;
    logic [7:0] dac_code;
    logic [11:0] chan_onehot;
    logic sample_hold;
    logic start_busy_flag;
    logic conv_end_request_flag;
    int errors = 0;
    int cmp_count = 0;
    logic [7:0] d;
    int n;
    logic fl;

    sadc_seq DUT (.clk(clk), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
        .ext_trigger_pin(ext_trigger_pin), .trigger_pin_function_bit(trigger_pin_function_bit),
        .trigger_edge_select(trigger_edge_select), .comp_out(comp_out), .dac_code(dac_code),
        .chan_onehot(chan_onehot), .sample_hold(sample_hold), .start_busy_flag(start_busy_flag),
        .conv_end_request_flag(conv_end_request_flag));
    sadc_analog_model analog (.chan_onehot(chan_onehot), .dac_code(dac_code), .levels(levels),
        .comp_out(comp_out));

    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Endpoints 00 and FF sit on channels 0 and 11 to catch a stuck decision bit.
    function automatic logic [7:0] lvl(input int i);
        if (i == 0) return 8'h00;
        if (i == 11) return 8'hFF;
        return 8'h0F + 8'(i) * 8'h13;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic wait_done(input logic [11:0] ec, output int cnt, output logic f);
        logic held;
        held = 1'b1;
        cnt = 0;
        while (start_busy_flag === 1'b1 && cnt < 200) begin
            if (chan_onehot !== ec) held = 1'b0;
            @(posedge clk);
            #1 cnt++;
        end
        f = conv_end_request_flag;
        chk("chan_held", {15'h0000, held}, 16'h0001);
    endtask
    task automatic conv(input logic [3:0] c, input logic fast);
        logic [11:0] ec;
        int cnt;
        logic f;
        ec = (c[3:2] == 2'b00) ? 12'h000 : 12'h001 << (c - 4'h4);
        wr(`SADC_OFS_MODE, {fast, 3'b011, c});
        wr(`SADC_OFS_START, 8'h80);
        #1;
        chk("busy_set", {15'h0000, start_busy_flag}, 16'h0001);
        chk("chan_sel", {4'h0, chan_onehot}, {4'h0, ec});
        wait_done(ec, cnt, f);
        chk("conv_len", 16'(cnt), fast ? 16'h001F : 16'h003E);
        chk("end_flag", {15'h0000, f}, 16'h0001);
        rd(`SADC_OFS_START, d);
        chk("start_idle", {8'h00, d}, 16'h007F);
        if (c[3:2] != 2'b00) begin
            rd(`SADC_OFS_RESULT, d);
            chk("result", {8'h00, d}, {8'h00, lvl(int'(c) - 4)});
        end
    endtask
    task automatic pin_to(input logic v, input logic busy_exp);
        @(posedge clk);
        ext_trigger_pin <= v;
        repeat (3) @(posedge clk);
        #1 chk("trig_start", {15'h0000, start_busy_flag}, {15'h0000, busy_exp});
    endtask

    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 12; i++) levels[i*8 +: 8] = lvl(i);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`SADC_OFS_MODE, d);
        chk("mode_reset", {8'h00, d}, 16'h0030);
        rd(`SADC_OFS_START, d);
        chk("start_reset", {8'h00, d}, 16'h007F);
        rd(16'hFFC7, d);
        chk("unmapped", {8'h00, d}, 16'h00FF);
        wr(`SADC_OFS_MODE, 8'h00);
        rd(`SADC_OFS_MODE, d);
        chk("mode_rsvd", {8'h00, d}, 16'h0030);
        wr(`SADC_OFS_START, 8'h00);
        rd(`SADC_OFS_START, d);
        chk("start_rsvd", {8'h00, d}, 16'h007F);
        $display("test registers done");
        // Back-to-back conversions on every channel code, speed alternating.
        for (int c = 0; c < 16; c++) conv(4'(c), c[0]);
        $display("test channels done");
        wr(`SADC_OFS_MODE, 8'h3A);
        wr(`SADC_OFS_START, 8'h80);
        repeat (10) @(posedge clk);
        wr(`SADC_OFS_START, 8'h00);
        #1 chk("abort_busy", {15'h0000, start_busy_flag}, 16'h0000);
        n = 0;
        repeat (70) begin
            @(posedge clk);
            #1 if (conv_end_request_flag === 1'b1) n++;
        end
        chk("abort_flag", 16'(n), 16'h0000);
        rd(`SADC_OFS_RESULT, d);
        chk("abort_result", {8'h00, d}, 16'h00FF);
        $display("test abort done");
        wr(`SADC_OFS_MODE, 8'h05);
        trigger_pin_function_bit <= 1'b1;
        pin_to(1'b1, 1'b0);
        pin_to(1'b0, 1'b0);
        wr(`SADC_OFS_MODE, 8'h45);
        trigger_pin_function_bit <= 1'b0;
        pin_to(1'b1, 1'b0);
        pin_to(1'b0, 1'b0);
        @(posedge clk);
        trigger_pin_function_bit <= 1'b1;
        pin_to(1'b1, 1'b1);
        wait_done(12'h002, n, fl);
        chk("trig_flag", {15'h0000, fl}, 16'h0001);
        pin_to(1'b0, 1'b0);
        @(posedge clk);
        trigger_edge_select <= 1'b0;
        pin_to(1'b1, 1'b0);
        pin_to(1'b0, 1'b1);
        wait_done(12'h002, n, fl);
        rd(`SADC_OFS_RESULT, d);
        chk("trig_result", {8'h00, d}, {8'h00, lvl(1)});
        wr(`SADC_OFS_MODE, 8'h05);
        $display("test trigger done");
        // A frozen clock enable stretches the conversion by exactly the frozen cycles.
        wr(`SADC_OFS_START, 8'h80);
        clk_en <= 1'b0;
        repeat (20) @(posedge clk);
        clk_en <= 1'b1;
        wait_done(12'h002, n, fl);
        chk("freeze_len", 16'(n), 16'h003E);
        chk("freeze_flag", {15'h0000, fl}, 16'h0001);
        rd(`SADC_OFS_RESULT, d);
        chk("freeze_result", {8'h00, d}, {8'h00, lvl(1)});
        $display("test freeze done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(`SADC_OFS_RESULT, d);
        chk("result_kept", {8'h00, d}, {8'h00, lvl(1)});
        rd(`SADC_OFS_MODE, d);
        chk("mode_again", {8'h00, d}, 16'h0030);
        $display("test reset done");
        summarize();
    end

    // A healthy run needs well under a tenth of this span.
    initial begin
        #300000;
        errors++;
        summarize();
    end
endmodule
